/* common/ira_pkg.sv */
// package of constants for the two-wire register access slave
package ira_pkg;

    // bus address selection: four straps map to 7'h74..7'h77
    localparam logic [6:0] IRA_ADDR_BASE  = 7'h74;
    localparam int         IRA_ADDR_W     = 7;

    // register file geometry
    localparam int         IRA_REG_NUM    = 32;
    localparam int         IRA_IDX_W      = 5;
    localparam logic [7:0] IRA_PTR_RST    = 8'h00;

    // fifo between bus receiver and register file
    localparam int         IRA_FIFO_W     = 13;
    localparam int         IRA_FIFO_D     = 16;

    // synchroniser depth and bit counter
    localparam int         IRA_SYNC_N     = 2;
    localparam logic [3:0] IRA_BIT_LAST   = 4'h8;

    // protocol states
    typedef enum logic [2:0]
    {
        IRA_IDLE   = 3'b000,
        IRA_ADDR   = 3'b001,
        IRA_ACK    = 3'b010,
        IRA_WRX    = 3'b011,
        IRA_RTX    = 3'b100,
        IRA_RACK   = 3'b101,
        IRA_IGNORE = 3'b110
    } ira_state_t;

endpackage : ira_pkg

/* rtl/ira_fifo.sv */
// parameterised valid/ready fifo for register writes
`timescale 1ns/10ps
module ira_fifo
    import ira_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)
(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // storage words
    logic [AW-1:0]    wr_q;          // write pointer
    logic [AW-1:0]    rd_q;          // read pointer
    logic [AW:0]      cnt_q;         // fill level
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];

    // pointer and level update
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // memory write, no reset needed
    always_ff @(posedge core_clk)
    begin
        if (push) mem[wr_q] <= in_data;
    end
endmodule : ira_fifo

/* rtl/ira_slave.sv */
// two-wire register access slave with strap address and write fifo
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module ira_slave
    import ira_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [1:0] addr_strap,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic [7:0]      reg_wdata,
    output logic [4:0]      reg_widx,
    output logic            reg_wstb,
    input  wire logic [7:0] reg_rdata,
    output logic [4:0]      reg_ridx,
    input  wire logic [7:0] reg_wmask
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage read only by second
    logic [1:0] scl_s_q;   // scl sync chain
    logic [1:0] sda_s_q;   // sda sync chain
    logic       scl_p_q;   // previous synced scl
    logic       sda_p_q;   // previous synced sda
    logic [3:0] strap_s_q; // strap sync chain, two 2-bit stages

    always_ff @(posedge core_clk)
    begin
        // strap chain runs through reset so it has settled by release
        strap_s_q <= {strap_s_q[1:0], addr_strap};
        if (rst)
        begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end

    // edge and condition decode; 25 MHz samples a 3.125 MHz clock 8 times
    wire scl_r  = scl_s_q[1] && !scl_p_q;
    wire scl_f  = !scl_s_q[1] && scl_p_q;
    wire start  = scl_s_q[1] && scl_p_q && sda_p_q && !sda_s_q[1];
    wire stop   = scl_s_q[1] && scl_p_q && !sda_p_q && sda_s_q[1];
    wire sda_v  = sda_s_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // strap capture after reset release
    logic [6:0] my_addr_q;   // selected bus address
    logic strap_done_q;      // strap taken once
    always_ff @(posedge core_clk)
    begin
        if (rst)
            my_addr_q <= IRA_ADDR_BASE;
        else if (!strap_done_q)
            my_addr_q <= IRA_ADDR_BASE | {5'h00, strap_s_q[3:2]};
    end
    always_ff @(posedge core_clk)
    begin
        if (rst) strap_done_q <= 1'b0;
        else     strap_done_q <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // protocol engine
    ira_state_t st_q;        // current state
    logic [3:0] bit_q;       // bits in this byte
    logic [7:0] sh_q;        // shift register
    logic       rd_q;        // transfer is a read
    logic       first_q;     // next write byte is index
    logic [4:0] ptr_q;       // register pointer
    logic       nack_q;      // master refused last read byte
    logic       f_valid_q;   // push request to fifo
    logic [12:0] f_data_q;   // {index, data}
    wire        f_ready;     // fifo has room

    wire        addr_hit = (sh_q[7:1] == my_addr_q);
    wire        byte_end = (bit_q == IRA_BIT_LAST);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_q      <= IRA_IDLE;
            bit_q     <= 4'h0;
            sh_q      <= 8'h00;
            rd_q      <= 1'b0;
            first_q   <= 1'b0;
            ptr_q     <= IRA_PTR_RST[4:0];
            nack_q    <= 1'b0;
            f_valid_q <= 1'b0;
            f_data_q  <= 13'h0000;
            sda_out   <= 1'b0;
            sda_oe    <= 1'b0;
        end
        else
        begin
            if (f_valid_q && f_ready)
                f_valid_q <= 1'b0;
            if (start)
            begin
                // start or repeated start keeps pointer
                st_q   <= IRA_ADDR;
                bit_q  <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (stop)
            begin
                st_q   <= IRA_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (st_q)
                    IRA_ADDR, IRA_WRX:
                    begin
                        if (scl_r && !byte_end)
                        begin
                            sh_q  <= {sh_q[6:0], sda_v};
                            bit_q <= bit_q + 4'h1;
                        end
                        else if (scl_f && byte_end)
                        begin
                            bit_q <= 4'h0;
                            if (st_q == IRA_ADDR)
                            begin
                                if (addr_hit)
                                begin
                                    rd_q    <= sh_q[0];
                                    first_q <= !sh_q[0];
                                    st_q    <= IRA_ACK;
                                    sda_oe  <= 1'b1;     // pull low to ack
                                end
                                else
                                    st_q <= IRA_IGNORE;
                            end
                            else if (first_q)
                            begin
                                ptr_q   <= sh_q[4:0];
                                first_q <= 1'b0;
                                st_q    <= IRA_ACK;
                                sda_oe  <= 1'b1;
                            end
                            else if (!f_valid_q)
                            begin
                                // data byte: queue write, advance index
                                f_data_q  <= {ptr_q, sh_q};
                                f_valid_q <= 1'b1;
                                ptr_q     <= ptr_q + 5'h01;
                                st_q      <= IRA_ACK;
                                sda_oe    <= 1'b1;
                            end
                            else
                                st_q <= IRA_IGNORE;      // overrun: no ack
                        end
                    end
                    IRA_ACK:
                    begin
                        // release after ack clock; load read data if reading
                        if (scl_f)
                        begin
                            if (rd_q)
                            begin
                                sh_q    <= reg_rdata;
                                ptr_q   <= ptr_q + 5'h01;
                                sda_out <= 1'b0;
                                sda_oe  <= !reg_rdata[7];
                                bit_q   <= 4'h1;
                                st_q    <= IRA_RTX;
                            end
                            else
                            begin
                                sda_oe <= 1'b0;
                                st_q   <= IRA_WRX;
                            end
                        end
                    end
                    IRA_RTX:
                    begin
                        // open-drain: drive only zeros
                        if (scl_f)
                        begin
                            if (byte_end)
                            begin
                                sda_oe <= 1'b0;
                                st_q   <= IRA_RACK;
                            end
                            else
                            begin
                                sh_q   <= {sh_q[6:0], 1'b0};
                                sda_oe <= !sh_q[6];
                                bit_q  <= bit_q + 4'h1;
                            end
                        end
                    end
                    IRA_RACK:
                    begin
                        if (scl_r)
                            nack_q <= sda_v;
                        else if (scl_f)
                        begin
                            if (nack_q)
                                st_q <= IRA_IGNORE;
                            else
                            begin
                                sh_q   <= reg_rdata;
                                ptr_q  <= ptr_q + 5'h01;
                                sda_oe <= !reg_rdata[7];
                                bit_q  <= 4'h1;
                                st_q   <= IRA_RTX;
                            end
                        end
                    end
                    IRA_IGNORE: sda_oe <= 1'b0;
                    default:    st_q   <= IRA_IDLE;
                endcase
            end
        end
    end

    // clock line is never driven: no scl output exists
    assign reg_ridx = ptr_q;

    ////////////////////////////////////////////////////////////////////////////
    // write fifo between bus and register file; read side tied ready, so it drains every cycle
    wire [12:0] q_data;
    wire        q_valid;
    ira_fifo #(
        .WIDTH (IRA_FIFO_W),
        .DEPTH (IRA_FIFO_D)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_data   (f_data_q),
        .in_valid  (f_valid_q),
        .in_ready  (f_ready),
        .out_data  (q_data),
        .out_valid (q_valid),
        .out_ready (1'b1)
    );

    // register write port; unused bits masked out
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            reg_wstb  <= 1'b0;
            reg_widx  <= 5'h00;
            reg_wdata <= 8'h00;
        end
        else
        begin
            reg_wstb  <= q_valid;
            reg_widx  <= q_data[12:8];
            reg_wdata <= q_data[7:0] & reg_wmask;
        end
    end
endmodule : ira_slave

/* test/ira_slave_properties.sv */
// concurrent checks on the register access slave ports
`timescale 1ns/10ps
module ira_slave_properties
    import ira_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [1:0] addr_strap,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic [7:0] reg_wdata,
    input wire logic [4:0] reg_widx,
    input wire logic       reg_wstb,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] reg_ridx,
    input wire logic [7:0] reg_wmask
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    logic       sda_q;                          // data line one cycle ago
    logic       seen_q;                         // a write landed since the last start
    logic [4:0] last_q;                         // index of that write
    wire        start_w = scl_in & sda_q & ~sda_in; // start seen on the pins

    // previous write index, forgotten at each start so bursts stand alone
    always_ff @(posedge core_clk)
    begin
        sda_q  <= sda_in;
        seen_q <= (seen_q | reg_wstb) & ~start_w & ~rst;
        if (reg_wstb)
            last_q <= reg_widx;
    end
    ////////////////////////////////////////////////////////////////////////////////
    drain_only_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    oe_clk_low_a: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
        else $error("data pin moved while clock high");
    ack_bit_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
        else $error("driven bit shorter than a bit time");
    line_free_a: assert property (scl_in && $changed(sda_in) |-> !sda_oe)
        else $error("device held data during start or stop");
    wstb_pulse_a: assert property (reg_wstb |=> !reg_wstb)
        else $error("write strobe longer than one cycle");
    idx_step_a: assert property (reg_wstb && seen_q |-> reg_widx == last_q + 5'h01)
        else $error("burst index did not advance by one");
    unused_bits_a: assert property (reg_wstb |-> (reg_wdata & ~reg_wmask) == 8'h00)
        else $error("unused bits reached the register");
    ptr_reset_a: assert property ($fell(rst) |-> reg_ridx == 5'h00)
        else $error("pointer not cleared by reset");
endmodule : ira_slave_properties

bind ira_slave ira_slave_properties u_props
(
    .core_clk(core_clk), .rst(rst), .addr_strap(addr_strap), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .reg_wdata(reg_wdata),
    .reg_widx(reg_widx), .reg_wstb(reg_wstb), .reg_rdata(reg_rdata),
    .reg_ridx(reg_ridx), .reg_wmask(reg_wmask)
);

/* test/ira_host_model.sv */
// host model: two-wire bus master on a pulled-up data line
`timescale 1ns/10ps
module ira_host_model
(
    input  wire logic core_clk,
    input  wire logic sda_oe,
    output logic      scl_in,
    output logic      sda_in
);
    logic sda_drv; // host side of the data line, 1 = released
    logic r;       // scratch bit

    // pull-up: the line is low while either party pulls it
    assign sda_in = sda_drv & ~sda_oe;

    // clock idles high and stands still between frames
    initial
    begin
        scl_in  = 1'b1;
        sda_drv = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one quarter of the 320 ns bit time; only the host moves the clock
    task step(input logic c, input logic d);
        scl_in  = c;
        sda_drv = d;
        repeat (2) @(negedge core_clk);
    endtask : step

    // start, or repeated start when the clock is low
    task start;
        step(scl_in, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask : start

    task stop;
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop

    // data changes a quarter after the fall, sampled mid-high
    task bit_io(input logic b, output logic v);
        step(1'b0, b);
        step(1'b1, b);
        v = sda_in;
        step(1'b1, b);
        step(1'b0, b);
    endtask : bit_io

    // byte msb first, ninth bit is the device acknowledge
    task wr(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr

    // read byte; last = 1 releases the ninth bit to end the burst
    task rd(input logic last, output logic [7:0] d);
        for (int i = 0; i < 8; i++)
        begin
            bit_io(1'b1, r);
            d = {d[6:0], r};
        end
        bit_io(last, r);
    endtask : rd
endmodule : ira_host_model

/* test/tb_top.sv */
// testbench for the two-wire register access slave
`timescale 1ns/10ps
module tb_top
    import ira_pkg::*;
;
    logic       core_clk   = 1'b0;
    logic       rst        = 1'b1;
    logic [1:0] addr_strap = 2'b00;
    logic       scl_in, sda_in, sda_out, sda_oe, reg_wstb;
    logic [7:0] reg_wdata, reg_rdata;
    logic [4:0] reg_widx, reg_ridx;
    logic [7:0] reg_wmask  = 8'h3F;        // top two bits unused
    logic [7:0] regs [32];                 // register file stand-in
    logic [7:0] dat [3] = '{8'hA5, 8'h5A, 8'hFF}; // nonzero payload, no zero profile
    logic [6:0] own;                       // selected bus address
    logic       a;
    logic [7:0] d;
    int         wcnt = 0;
    int         errors = 0;
    int         n_compared = 0;

    ira_slave uut
    (
        .core_clk(core_clk), .rst(rst), .addr_strap(addr_strap), .scl_in(scl_in),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .reg_wdata(reg_wdata),
        .reg_widx(reg_widx), .reg_wstb(reg_wstb), .reg_rdata(reg_rdata),
        .reg_ridx(reg_ridx), .reg_wmask(reg_wmask)
    );
    ira_host_model host (.core_clk(core_clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

    assign reg_rdata = regs[reg_ridx];
    always #20 core_clk = ~core_clk;

    // register file stand-in, counts every write
    initial
        foreach (regs[i]) regs[i] = 8'h00;
    always @(posedge core_clk)
    begin
        if (reg_wstb)
        begin
            regs[reg_widx] <= reg_wdata;
            wcnt           <= wcnt + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task final_report;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    // strap must be steady when reset lets go
    task do_reset(input logic [1:0] s);
        addr_strap = s;
        rst = 1'b1;
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        repeat (8) @(negedge core_clk); // settle before traffic, no ramp modelled
    endtask : do_reset

    // bounded wait for the write count; giving up ends the run
    task wait_wr(input int n);
        for (int k = 0; k < 200 && wcnt < n; k++)
            @(negedge core_clk);
        if (wcnt < n)
        begin
            errors++;
            final_report();
        end
    endtask : wait_wr

    task wr_chk(input logic [7:0] b, input logic exp);
        host.wr(b, a);
        check({7'h00, a}, {7'h00, exp});
    endtask : wr_chk
    ////////////////////////////////////////////////////////////////////////////////
    // each strap selects one address; strangers get no acknowledge
    task t_addr;
        for (int s = 0; s < 4; s++)
        begin
            do_reset(2'(s));
            own = IRA_ADDR_BASE | {5'h00, 2'(s)};
            host.start();
            wr_chk({own, 1'b0}, 1'b1);
            host.stop();
            host.start();
            wr_chk({own ^ 7'h01, 1'b0}, 1'b0);
            wr_chk(8'h05, 1'b0);
            host.stop();
        end
        host.start();
        wr_chk(8'hF0, 1'b0);
        host.stop();
        $display("t_addr done");
    endtask : t_addr

    // burst that wraps the index past the top of the file
    task t_write;
        logic [4:0] ix;
        int         n0;
        n0 = wcnt;
        host.start();
        wr_chk({own, 1'b0}, 1'b1);
        wr_chk(8'h1E, 1'b1);
        for (int i = 0; i < 3; i++)
            wr_chk(dat[i], 1'b1);
        host.stop();
        wait_wr(n0 + 3);
        ix = 5'h1E;
        for (int i = 0; i < 3; i++)
        begin
            check(regs[ix], dat[i] & reg_wmask);
            ix = ix + 5'h01;
        end
        $display("t_write done");
    endtask : t_write

    // pointer set by index-only writes, both restart forms
    task t_read;
        int n0;
        n0 = wcnt;
        host.start();
        wr_chk({own, 1'b0}, 1'b1);
        wr_chk(8'h1E, 1'b1);
        host.start();
        wr_chk({own, 1'b1}, 1'b1);
        host.rd(1'b0, d);
        check(d, dat[0] & reg_wmask);
        host.rd(1'b1, d);
        check(d, dat[1] & reg_wmask);
        host.stop();
        host.start();
        wr_chk({own, 1'b0}, 1'b1);
        wr_chk(8'h00, 1'b1);
        host.stop();
        host.start();
        wr_chk({own, 1'b1}, 1'b1);
        host.rd(1'b1, d);
        check(d, dat[2] & reg_wmask);
        host.stop();
        check(8'(wcnt - n0), 8'h00);
        $display("t_read done");
    endtask : t_read

    initial
    begin
        t_addr();
        t_write();
        t_read();
        final_report();
    end
endmodule : tb_top
